// ===== src/standby_supply_mode_control.sv
// Overview of operation
// [RQ1] weak-battery interrupt on either comparator edge
// [RQ2] low-battery interrupt only on falling crossing
// [RQ3] sense bits coded from three comparator levels
// [RQ4] two-bit threshold select, resets to lowest
// [RQ5] standby needs both pins active together
// [RQ6] pins only matter in the On state
// [RQ7] low-power off request overrides standby
// [RQ8] each pin level XORed with its invert
// [RQ9] entry waits 0-3 slow ticks, default one
// [RQ10] leaving standby restores supplies at once
// [RQ11] external-pass regulator state from its bits
// [RQ12] internal regulators with standby_disable set turn off in standby
// [RQ13] regulator bits read back as programmed
// [RQ14] switcher field decodes normal and standby mode
// [RQ15] switcher field reads back as programmed
// [RQ16] pins pass two flip-flops before use
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module standby_supply_mode_control
  import standby_supply_pkg::*;
#(
  parameter int unsigned N_EXT = 4,
  parameter int unsigned N_INT = 8,
  parameter int unsigned N_SW  = 4
)(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // register port
  input  wire bus_req_t            bus_req,
  output logic [DATA_W-1:0]        rd_data,
  // board standby pins
  input  wire logic                sleep_pin,
  input  wire logic                secondary_sleep_pin,
  // battery comparators
  input  wire batt_level_t         batt_level,
  output logic [1:0]               battery_threshold_select,
  // power state machine
  input  wire logic                on_state,
  output logic                     lowpower_off_request,
  output logic                     standby_active,
  // supply controls
  output ldo_state_t [N_EXT-1:0]   ext_ldo_state,
  output logic [N_INT-1:0]         int_ldo_on,
  output sw_mode_t [N_SW-1:0]      sw_active_mode,
  output logic [N_SW-1:0]          sw_mode_invalid,
  // interrupt
  output logic                     irq
);

  if (N_EXT < 1 || N_EXT * EXT_FLD_W > DATA_W || N_INT < 1 ||
      N_INT * INT_FLD_W > DATA_W || N_SW < 1 || N_SW * SW_FLD_W > DATA_W)
  begin : g_bad_params
    $error("regulator or switcher count does not fit a register word");
  end

  // ----------------------------------------
  // slow tick divider
  // ----------------------------------------
  localparam int unsigned DIV_W = $clog2(SLOW_DIV);

  logic [DIV_W-1:0] div_q;
  logic             tick;

  assign tick = (div_q == DIV_W'(SLOW_DIV - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst || tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0]  pin_s;
  batt_level_t lvl_s;
  batt_level_t lvl_q;
  logic [2:0]  prime_q;

  sync2 #(.W(2)) u_pin_sync (                                        // [RQ16]
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({secondary_sleep_pin, sleep_pin}),
    .sync_out (pin_s)
  );

  sync2 #(.W(3)) u_lvl_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (batt_level),
    .sync_out (lvl_s)
  );

  // edges are ignored until the pipeline holds real levels, else reset
  // would fake a crossing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lvl_q   <= '0;
      prime_q <= '0;
    end
    else
    begin
      lvl_q   <= lvl_s;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0]                  thr_q;
  logic                        slp_inv_q;
  logic                        sec_inv_q;
  logic [1:0]                  dly_q;
  logic                        lpoff_q;
  logic [IRQ_W-1:0]            irq_stat_q;
  logic [IRQ_W-1:0]            irq_mask_q;
  logic [IRQ_W-1:0]            irq_event;
  logic [IRQ_W-1:0]            irq_clr;
  ext_ldo_bits_t [N_EXT-1:0]   ext_q;
  int_ldo_bits_t [N_INT-1:0]   int_q;
  logic [N_SW*SW_FLD_W-1:0]    sw_q;

  logic sel_ctrl;
  logic sel_stat;
  logic sel_mask;
  logic sel_sense;
  logic sel_ext;
  logic sel_int;
  logic sel_sw;

  assign sel_ctrl  = (bus_req.addr == CTRL_OFF);
  assign sel_stat  = (bus_req.addr == IRQ_STAT_OFF);
  assign sel_mask  = (bus_req.addr == IRQ_MASK_OFF);
  assign sel_sense = (bus_req.addr == SENSE_OFF);
  assign sel_ext   = (bus_req.addr == EXT_REG_OFF);
  assign sel_int   = (bus_req.addr == INT_REG_OFF);
  assign sel_sw    = (bus_req.addr == SW_MODE_OFF);

  assign irq_clr = (bus_req.wr && sel_stat) ? bus_req.wdata[IRQ_W-1:0] : '0;

  assign irq_event[IRQ_WEAK_BIT] = prime_q[2] &&
    (lvl_s.weak_battery_level != lvl_q.weak_battery_level);          // [RQ1]
  assign irq_event[IRQ_LOW_BIT]  = prime_q[2] &&
    lvl_q.low_battery_level && !lvl_s.low_battery_level;             // [RQ2]

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      thr_q      <= THR_RST;                                          // [RQ4]
      slp_inv_q  <= INV_RST;
      sec_inv_q  <= INV_RST;
      dly_q      <= DLY_RST;                                          // [RQ9]
      lpoff_q    <= LPOFF_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      ext_q      <= '0;
      int_q      <= '0;
      sw_q       <= '0;
    end
    else
    begin
      if (bus_req.wr && sel_ctrl)
      begin
        thr_q     <= bus_req.wdata[THR_LSB +: 2];
        slp_inv_q <= bus_req.wdata[SLP_INV_BIT];
        sec_inv_q <= bus_req.wdata[SEC_INV_BIT];
        dly_q     <= bus_req.wdata[DLY_LSB +: 2];
        lpoff_q   <= bus_req.wdata[LPOFF_BIT];
      end
      if (bus_req.wr && sel_mask)
        irq_mask_q <= bus_req.wdata[IRQ_W-1:0];
      if (bus_req.wr && sel_ext)
        ext_q <= bus_req.wdata[N_EXT*EXT_FLD_W-1:0];
      if (bus_req.wr && sel_int)
        int_q <= bus_req.wdata[N_INT*INT_FLD_W-1:0];
      if (bus_req.wr && sel_sw)
        sw_q <= bus_req.wdata[N_SW*SW_FLD_W-1:0];
      // a new event beats a clear in the same cycle
      irq_stat_q <= irq_event | (irq_stat_q & ~irq_clr);
    end
  end

  assign irq                      = |(irq_stat_q & irq_mask_q);
  assign battery_threshold_select = thr_q;                            // [RQ4]
  assign lowpower_off_request     = lpoff_q;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] sense_word;
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    ctrl_word                  = '0;
    ctrl_word[THR_LSB +: 2]    = thr_q;
    ctrl_word[SLP_INV_BIT]     = slp_inv_q;
    ctrl_word[SEC_INV_BIT]     = sec_inv_q;
    ctrl_word[DLY_LSB +: 2]    = dly_q;
    ctrl_word[LPOFF_BIT]       = lpoff_q;
    sense_word                 = '0;
    sense_word[SENSE_LOW_BIT]  = !lvl_s.low_battery_level;            // [RQ3]
    sense_word[SENSE_WEAK_BIT] = lvl_s.weak_battery_level;
    sense_word[SENSE_ON_BIT]   = lvl_s.battery_turn_on_level;
    sense_word[SENSE_STBY_BIT] = standby_active;
  end

  always_comb
  begin
    rd_mux = '0;
    if (sel_ctrl)
      rd_mux = ctrl_word;
    else if (sel_stat)
      rd_mux = DATA_W'(irq_stat_q);
    else if (sel_mask)
      rd_mux = DATA_W'(irq_mask_q);
    else if (sel_sense)
      rd_mux = sense_word;
    else if (sel_ext)
      rd_mux = DATA_W'(ext_q);                                        // [RQ13]
    else if (sel_int)
      rd_mux = DATA_W'(int_q);                                        // [RQ13]
    else if (sel_sw)
      rd_mux = DATA_W'(sw_q);                                         // [RQ15]
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst || !bus_req.rd)
      rd_data <= '0;
    else
      rd_data <= rd_mux;
  end

  // ----------------------------------------
  // standby decode and entry delay
  // ----------------------------------------
  logic        eff_pri;
  logic        eff_sec;
  logic        pins_active;
  logic        stby_req;
  logic        stby_eff;
  stby_state_t stby_state_q;
  stby_state_t stby_state_d;
  logic [1:0]  cnt_q;

  assign eff_pri     = pin_s[0] ^ slp_inv_q;                          // [RQ8]
  assign eff_sec     = pin_s[1] ^ sec_inv_q;                          // [RQ8]
  assign pins_active = eff_pri && eff_sec;                            // [RQ5]
  assign stby_req    = pins_active && on_state && !lpoff_q;           // [RQ6] [RQ7]
  // release is combinational so no delay is added on exit
  assign stby_eff    = (stby_state_q == STBY_ACTIVE) && stby_req;     // [RQ10]

  always_comb
  begin
    stby_state_d = stby_state_q;
    case (stby_state_q)
      STBY_IDLE:
        if (stby_req)
          stby_state_d = (dly_q == 2'h0) ? STBY_ACTIVE : STBY_WAIT;   // [RQ9]
      STBY_WAIT:
        if (!stby_req)
          stby_state_d = STBY_IDLE;
        else if (tick && (cnt_q + 2'h1 == dly_q))
          stby_state_d = STBY_ACTIVE;                                 // [RQ9]
      STBY_ACTIVE:
        if (!stby_req)
          stby_state_d = STBY_IDLE;                                   // [RQ10]
      default:
        stby_state_d = STBY_IDLE;
    endcase
  end

  // the first tick may land anywhere in a slow period, so the wait is
  // between dly-1 and dly slow periods
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stby_state_q <= STBY_IDLE;
      cnt_q        <= '0;
    end
    else
    begin
      stby_state_q <= stby_state_d;
      if (stby_state_q == STBY_WAIT && tick)
        cnt_q <= cnt_q + 2'h1;
      else if (stby_state_q != STBY_WAIT)
        cnt_q <= '0;
    end
  end

  // ----------------------------------------
  // supply decode
  // ----------------------------------------
  sw_mode_t [N_SW-1:0] dec_mode;
  logic [N_SW-1:0]     dec_inv;
  ldo_state_t [N_EXT-1:0] ext_d;
  logic [N_INT-1:0]    int_d;

  for (genvar i = 0; i < N_EXT; i++)
  begin : g_ext
    assign ext_d[i] =
      !ext_q[i].regulator_enable_bit ? LDO_OFF :
      ext_q[i].low_power_select      ? LDO_LOWPWR :
      (ext_q[i].standby_disable && stby_eff) ? LDO_OFF : LDO_ON;      // [RQ11]
  end

  for (genvar i = 0; i < N_INT; i++)
  begin : g_int
    assign int_d[i] = int_q[i].regulator_enable_bit &&
                      !(int_q[i].standby_disable && stby_eff);        // [RQ12]
  end

  for (genvar i = 0; i < N_SW; i++)
  begin : g_sw
    switcher_mode_decode u_dec (                                      // [RQ14]
      .mode_sel    (sw_q[i*SW_FLD_W +: SW_FLD_W]),
      .standby     (stby_eff),
      .active_mode (dec_mode[i]),
      .invalid     (dec_inv[i])
    );
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ext_ldo_state   <= {N_EXT{LDO_OFF}};
      int_ldo_on      <= '0;
      sw_active_mode  <= {N_SW{SW_OFF}};
      sw_mode_invalid <= '0;
      standby_active  <= 1'b0;
    end
    else
    begin
      ext_ldo_state   <= ext_d;
      int_ldo_on      <= int_d;
      sw_active_mode  <= dec_mode;
      sw_mode_invalid <= dec_inv;
      standby_active  <= stby_eff;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [15:0] wait_cyc_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst || stby_state_q == STBY_IDLE)
      wait_cyc_q <= '0;
    else if (stby_state_q == STBY_WAIT)
      wait_cyc_q <= wait_cyc_q + 16'h1;
  end

  sequence s_wait_done;
    stby_state_q == STBY_WAIT ##1 stby_state_q == STBY_ACTIVE;
  endsequence

  sequence s_release;
    stby_state_q == STBY_ACTIVE && !stby_req;
  endsequence

  chk_weak_irq_edge: assert property ( // [RQ1]
    prime_q[2] && $changed(lvl_s.weak_battery_level)
      |=> irq_stat_q[IRQ_WEAK_BIT])
    else $error("weak battery edge did not set its flag");

  chk_low_irq_fall: assert property ( // [RQ2]
    (!irq_stat_q[IRQ_LOW_BIT] && !irq_event[IRQ_LOW_BIT])
      |=> !irq_stat_q[IRQ_LOW_BIT])
    else $error("low battery flag set without a falling crossing");

  chk_sense_read: assert property ( // [RQ3]
    bus_req.rd && sel_sense
      |=> rd_data[SENSE_LOW_BIT] == !$past(lvl_s.low_battery_level, 1) &&
          rd_data[SENSE_WEAK_BIT] == $past(lvl_s.weak_battery_level, 1))
    else $error("sense bits do not follow the comparators");

  chk_stby_both_pins: assert property ( // [RQ5]
    standby_active |-> $past(eff_pri, 1) && $past(eff_sec, 1) &&
                       $past(on_state, 1) && !$past(lpoff_q, 1))
    else $error("standby active without both pins, On state or no off request");

  chk_entry_delay: assert property ( // [RQ9]
    s_wait_done |-> int'(wait_cyc_q) >= (int'(dly_q) - 1) * int'(SLOW_DIV) &&
                    int'(wait_cyc_q) <= int'(dly_q) * int'(SLOW_DIV) + 1)
    else $error("standby entry delay out of range");

  chk_no_delay_zero: assert property ( // [RQ9]
    stby_state_q == STBY_IDLE ##1 stby_state_q == STBY_ACTIVE
      |-> $past(dly_q, 1) == 2'h0)
    else $error("standby entered at once with nonzero delay");

  chk_exit_at_once: assert property ( // [RQ10]
    s_release |=> !standby_active && stby_state_q == STBY_IDLE)
    else $error("standby not released at once");

  chk_ext_ldo_state: assert property ( // [RQ11]
    !ext_q[0].regulator_enable_bit ##1 !ext_q[0].regulator_enable_bit
      |-> ext_ldo_state[0] == LDO_OFF)
    else $error("disabled external regulator not off");

  chk_int_ldo_stby: assert property ( // [RQ12]
    stby_eff && int_q[0].standby_disable |=> !int_ldo_on[0])
    else $error("internal regulator on during standby");

  chk_ext_readback: assert property ( // [RQ13]
    bus_req.rd && sel_ext && !bus_req.wr
      |=> rd_data[N_EXT*EXT_FLD_W-1:0] == $past(ext_q, 1))
    else $error("regulator bits not read back as written");

  chk_sw_pfm_code: assert property ( // [RQ14]
    sw_q[SW_FLD_W-1:0] == 4'hf |=> sw_active_mode[0] == SW_PFM)
    else $error("switcher code 1111 not decoded as PFM");

  chk_sw_readback: assert property ( // [RQ15]
    bus_req.rd && sel_sw |=> rd_data[N_SW*SW_FLD_W-1:0] == $past(sw_q, 1))
    else $error("switcher field not read back as written");

endmodule

// ===== src/standby_supply_pkg.sv
package standby_supply_pkg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned SLOW_HZ  = 32_768;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;

  // ----------------------------------------
  // register port and offsets
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] CTRL_OFF     = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] SENSE_OFF    = 8'h0c;
  localparam logic [ADDR_W-1:0] EXT_REG_OFF  = 8'h10;
  localparam logic [ADDR_W-1:0] INT_REG_OFF  = 8'h14;
  localparam logic [ADDR_W-1:0] SW_MODE_OFF  = 8'h18;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned THR_LSB     = 0;
  localparam int unsigned SLP_INV_BIT = 2;
  localparam int unsigned SEC_INV_BIT = 3;
  localparam int unsigned DLY_LSB     = 4;
  localparam int unsigned LPOFF_BIT   = 6;

  localparam logic [1:0] THR_RST   = 2'h0;
  localparam logic [1:0] DLY_RST   = 2'h1;
  localparam logic       INV_RST   = 1'h0;
  localparam logic       LPOFF_RST = 1'h0;

  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_WEAK_BIT = 0;
  localparam int unsigned IRQ_LOW_BIT  = 1;

  localparam int unsigned SENSE_LOW_BIT  = 0;
  localparam int unsigned SENSE_WEAK_BIT = 1;
  localparam int unsigned SENSE_ON_BIT   = 2;
  localparam int unsigned SENSE_STBY_BIT = 3;

  localparam int unsigned EXT_FLD_W = 3;
  localparam int unsigned INT_FLD_W = 2;
  localparam int unsigned SW_FLD_W  = 4;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SW_OFF   = 3'b000,
    SW_PWM   = 3'b001,
    SW_PWM_PULSE_SKIPPING = 3'b010,
    SW_PFM   = 3'b011,
    SW_AUTO  = 3'b100,
    SW_NA    = 3'b111
  } sw_mode_t;

  typedef enum logic [1:0] {
    LDO_OFF    = 2'b00,
    LDO_ON     = 2'b01,
    LDO_LOWPWR = 2'b10
  } ldo_state_t;

  typedef enum logic [1:0] {
    STBY_IDLE   = 2'b00,
    STBY_WAIT   = 2'b01,
    STBY_ACTIVE = 2'b10
  } stby_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic battery_turn_on_level;
    logic weak_battery_level;
    logic low_battery_level;
  } batt_level_t;

  typedef struct packed {
    logic regulator_enable_bit;
    logic low_power_select;
    logic standby_disable;
  } ext_ldo_bits_t;

  typedef struct packed {
    logic regulator_enable_bit;
    logic standby_disable;
  } int_ldo_bits_t;

endpackage

// ===== src/sync2.sv
`timescale 1ns/1ps
module sync2
  import standby_supply_pkg::*;
#(
  parameter int unsigned W = 1
)(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  if (W < 1) begin : g_bad_width
    $error("sync2 needs a width of at least one");
  end

  // first stage feeds only the second stage
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== src/switcher_mode_decode.sv
`timescale 1ns/1ps
module switcher_mode_decode
  import standby_supply_pkg::*;
(
  // selection
  input  wire logic [SW_FLD_W-1:0] mode_sel,
  input  wire logic                standby,
  // decoded mode
  output sw_mode_t                 active_mode,
  output logic                     invalid
);

  sw_mode_t norm_mode;
  sw_mode_t stby_mode;

  always_comb
  begin
    norm_mode = SW_NA;
    stby_mode = SW_NA;
    case (mode_sel)
      4'h0: begin norm_mode = SW_OFF;   stby_mode = SW_OFF;   end
      4'h1: begin norm_mode = SW_PWM;   stby_mode = SW_OFF;   end
      4'h2: begin norm_mode = SW_PWM_PULSE_SKIPPING; stby_mode = SW_OFF;   end
      4'h3: begin norm_mode = SW_PFM;   stby_mode = SW_OFF;   end
      4'h4: begin norm_mode = SW_AUTO;  stby_mode = SW_OFF;   end
      4'h5: begin norm_mode = SW_PWM;   stby_mode = SW_PWM;   end
      4'h6: begin norm_mode = SW_PWM;   stby_mode = SW_AUTO;  end
      4'h8: begin norm_mode = SW_AUTO;  stby_mode = SW_AUTO;  end
      4'h9: begin norm_mode = SW_PWM;   stby_mode = SW_PWM_PULSE_SKIPPING; end
      4'ha: begin norm_mode = SW_PWM_PULSE_SKIPPING; stby_mode = SW_PWM_PULSE_SKIPPING; end
      4'hb: begin norm_mode = SW_PWM_PULSE_SKIPPING; stby_mode = SW_AUTO;  end
      4'hc: begin norm_mode = SW_AUTO;  stby_mode = SW_PFM;   end
      4'hd: begin norm_mode = SW_PWM;   stby_mode = SW_PFM;   end
      4'he: begin norm_mode = SW_PWM_PULSE_SKIPPING; stby_mode = SW_PFM;   end
      4'hf: begin norm_mode = SW_PFM;   stby_mode = SW_PFM;   end
      default: begin norm_mode = SW_NA; stby_mode = SW_NA;    end
    endcase
  end

  // 0111 is not a legal code; the supply side must treat SW_NA as off
  assign invalid     = (mode_sel == 4'h7);
  assign active_mode = standby ? stby_mode : norm_mode;

endmodule

// ===== test/host_pins.sv
`timescale 1ns/1ps
module host_pins (
  // clock
  input  wire logic ref_clk,
  // wanted standby per pin and the polarity software programmed
  input  wire logic want_pri,
  input  wire logic want_sec,
  input  wire logic inv_pri,
  input  wire logic inv_sec,
  // board pins
  output logic      sleep_pin,
  output logic      secondary_sleep_pin
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  initial
  begin
    sleep_pin           = 1'b0;
    secondary_sleep_pin = 1'b0;
  end

  // pins move just after an edge, as board logic would
  always @(posedge ref_clk)
  begin
    sleep_pin           <= want_pri ^ inv_pri;
    secondary_sleep_pin <= want_sec ^ inv_sec;
  end
endmodule

// ===== test/standby_supply_mode_control_tb.sv
`timescale 1ns/1ps
module standby_supply_mode_control_tb
  import standby_supply_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                ref_clk;
  logic                rst;
  bus_req_t            req;
  logic [DATA_W-1:0]   rd_data;
  logic                sleep_pin;
  logic                secondary_sleep_pin;
  batt_level_t         batt_level;
  logic [1:0]          thr;
  logic                on_state;
  logic                lpoff;
  logic                standby_active;
  ldo_state_t [3:0]    ext_ldo_state;
  logic [7:0]          int_ldo_on;
  sw_mode_t [3:0]      sw_mode;
  logic [3:0]          sw_bad;
  logic                irq;
  logic                want_pri;
  logic                want_sec;
  logic                inv_pri;
  logic                inv_sec;
  logic [31:0]         d;
  int                  n;
  int                  errors;
  int                  checks;
  logic [2:0]          lv [6] = '{3'h3, 3'h1, 3'h0, 3'h1, 3'h3, 3'h7};
  logic [1:0]          st [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
  logic [3:0]          sn [6] = '{4'h2, 4'h0, 4'h1, 4'h0, 4'h2, 4'h6};
  sw_mode_t            nrm [16] = '{SW_OFF, SW_PWM, SW_PWM_PULSE_SKIPPING, SW_PFM, SW_AUTO, SW_PWM, SW_PWM,
    SW_NA, SW_AUTO, SW_PWM, SW_PWM_PULSE_SKIPPING, SW_PWM_PULSE_SKIPPING, SW_AUTO, SW_PWM, SW_PWM_PULSE_SKIPPING, SW_PFM};
  sw_mode_t            sby [16] = '{SW_OFF, SW_OFF, SW_OFF, SW_OFF, SW_OFF, SW_PWM, SW_AUTO,
    SW_NA, SW_AUTO, SW_PWM_PULSE_SKIPPING, SW_PWM_PULSE_SKIPPING, SW_AUTO, SW_PFM, SW_PFM, SW_PFM, SW_PFM};

  standby_supply_mode_control standby_supply_mode_control_i (
    .ref_clk(ref_clk), .rst(rst), .bus_req(req), .rd_data(rd_data),
    .sleep_pin(sleep_pin), .secondary_sleep_pin(secondary_sleep_pin),
    .batt_level(batt_level), .battery_threshold_select(thr), .on_state(on_state),
    .lowpower_off_request(lpoff), .standby_active(standby_active),
    .ext_ldo_state(ext_ldo_state), .int_ldo_on(int_ldo_on), .sw_active_mode(sw_mode),
    .sw_mode_invalid(sw_bad), .irq(irq));

  host_pins host_pins_i (
    .ref_clk(ref_clk), .want_pri(want_pri), .want_sec(want_sec), .inv_pri(inv_pri),
    .inv_sec(inv_sec), .sleep_pin(sleep_pin), .secondary_sleep_pin(secondary_sleep_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // settle delay lets the taking edge's updates land before sampling
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic wait_sa(input logic e, input int mx, input bit must, output int k);
    #1;
    k = 0;
    while (standby_active !== e && k < mx)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (must && standby_active !== e)
    begin
      chk(32'(standby_active), 32'(e));
      conclude();
    end
  endtask

  task automatic pins(input logic p, input logic s);
    @(posedge ref_clk);
    want_pri <= p;
    want_sec <= s;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1; on_state = 1'b0; batt_level = batt_level_t'(3'h7); req = '0;
    want_pri = 1'b0; want_sec = 1'b0; inv_pri = 1'b0; inv_sec = 1'b0; errors = 0; checks = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_OFF, d); chk(d, 32'h10);
    chk(32'(thr), 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(CTRL_OFF, 32'h10 | k); chk(32'(thr), k);
    end
    wr(8'h1c, 32'hffff_ffff); rd(8'h1c, d); chk(d, 32'h0);
    wr(IRQ_MASK_OFF, 32'h3); wr(IRQ_STAT_OFF, 32'h3);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk); batt_level <= batt_level_t'(lv[i]); repeat (6) @(posedge ref_clk);
      rd(IRQ_STAT_OFF, d); chk(d, 32'(st[i]));
      chk(32'(irq), 32'(st[i] != 2'h0));
      rd(SENSE_OFF, d); chk(d, 32'(sn[i]));
      wr(IRQ_STAT_OFF, 32'h3);
    end
    wr(IRQ_MASK_OFF, 32'h1); @(posedge ref_clk); batt_level <= batt_level_t'(3'h0);
    repeat (6) @(posedge ref_clk);
    rd(IRQ_STAT_OFF, d); chk(d, 32'h3);
    wr(IRQ_STAT_OFF, 32'h1); chk(32'(irq), 32'h0);
    rd(IRQ_STAT_OFF, d); chk(d, 32'h2);
    wr(EXT_REG_OFF, 32'h9e8); wr(INT_REG_OFF, 32'h787b); wr(CTRL_OFF, 32'h0);
    @(posedge ref_clk); on_state <= 1'b1; batt_level <= batt_level_t'(3'h7);
    repeat (6) @(posedge ref_clk); #1;
    chk(32'(ext_ldo_state), 32'h64); chk(32'(int_ldo_on), 32'h67);
    pins(1'b1, 1'b1); wait_sa(1'b1, 10, 1'b1, n);
    @(posedge ref_clk); #1;
    chk(32'(ext_ldo_state), 32'h60); chk(32'(int_ldo_on), 32'h22);
    rd(EXT_REG_OFF, d); chk(d, 32'h9e8);
    rd(INT_REG_OFF, d); chk(d, 32'h787b);
    rd(SENSE_OFF, d); chk(d, 32'he);
    for (int k = 0; k < 16; k++)
    begin
      wr(SW_MODE_OFF, {4{k[3:0]}}); @(posedge ref_clk); #1;
      chk(32'(sw_mode), 32'({4{sby[k]}})); chk(32'(sw_bad), (k == 7) ? 32'hf : 32'h0);
    end
    rd(SW_MODE_OFF, d); chk(d, 32'hffff);
    pins(1'b1, 1'b0); wait_sa(1'b0, 6, 1'b1, n);
    wait_sa(1'b1, 30, 1'b0, n); chk(32'(standby_active), 32'h0);
    for (int k = 0; k < 16; k++)
    begin
      wr(SW_MODE_OFF, {4{k[3:0]}}); @(posedge ref_clk); #1;
      chk(32'(sw_mode), 32'({4{nrm[k]}}));
    end
    @(posedge ref_clk); on_state <= 1'b0; want_sec <= 1'b1;
    wait_sa(1'b1, 30, 1'b0, n); chk(32'(standby_active), 32'h0);
    wr(CTRL_OFF, 32'h40); @(posedge ref_clk); on_state <= 1'b1;
    wait_sa(1'b1, 30, 1'b0, n); chk(32'(standby_active), 32'h0);
    chk(32'(lpoff), 32'h1);
    @(posedge ref_clk); on_state <= 1'b0; wr(CTRL_OFF, 32'h0c);
    @(posedge ref_clk); inv_pri <= 1'b1; inv_sec <= 1'b1; want_pri <= 1'b0; want_sec <= 1'b0;
    repeat (4) @(posedge ref_clk); on_state <= 1'b1;
    wait_sa(1'b1, 20, 1'b0, n); chk(32'(standby_active), 32'h0);
    pins(1'b1, 1'b1); wait_sa(1'b1, 10, 1'b1, n);
    for (int k = 0; k < 4; k++)
    begin
      pins(1'b0, 1'b0); wait_sa(1'b0, 10, 1'b1, n);
      wr(CTRL_OFF, 32'h0c | (k << 4)); pins(1'b1, 1'b1); wait_sa(1'b1, 2000, 1'b1, n);
      chk(32'(n >= ((k == 0) ? 0 : (k - 1) * SLOW_DIV) && n <= k * SLOW_DIV + 8), 32'h1);
    end
    conclude();
  end
endmodule
